/* logic/gpr_top.v */
// Seventeen-pin port with AHB-Lite registers and timer/trace pin routing
`include "gpr_defines.vh"
`default_nettype none
module gpr_top #(
  parameter NPINS = 17
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [NPINS-1:0] pin_in,
  output reg [NPINS-1:0] pin_out,
  output reg [NPINS-1:0] pin_oe,
  input wire timer_one_output_a,
  input wire timer_one_output_b,
  input wire timer_two_output_a,
  input wire timer_two_output_b,
  input wire trace_frame_enable,
  input wire trace_serial_out,
  output reg timer_one_capture_a,
  output reg timer_one_capture_b,
  output reg timer_two_capture_a,
  output reg timer_two_capture_b,
  output reg timer_one_ext_clock,
  output reg timer_two_ext_clock,
  output reg timer_one_enable_mask,
  output reg timer_two_enable_mask,
  output reg ext_interrupt_a,
  output reg ext_interrupt_b,
  output reg ext_interrupt_c,
  output reg ext_interrupt_d
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WRITE = 2'h1;
  localparam ST_READ = 2'h2;

  // Register state
  reg [`GPR_CFG_W-1:0] cfg_r;
  reg out_up_r;
  reg [15:0] out_lo_r;
  reg drv_up_r;
  reg [15:0] drv_lo_r;

  // Bus state
  reg [1:0] state_r;
  reg [15:0] idx_r;
  reg [31:0] rd_nxt;

  wire [NPINS-1:0] lvl;
  wire addr_take;
  wire rt_t1a;
  wire rt_t1b;
  wire rt_t2a;
  wire rt_t2b;
  wire [NPINS-1:0] gp_out;
  wire [NPINS-1:0] gp_oe;
  reg [NPINS-1:0] pin_out_nxt;
  reg [NPINS-1:0] pin_oe_nxt;

  // Pins come from outside the clock domain
  gpr_sync #(
    .WIDTH(NPINS)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pin_in),
    .level(lvl)
  );

  gpr_route u_route (
    .code(cfg_r[`GPR_CFG_CODE_MSB:`GPR_CFG_CODE_LSB]),
    .lvl(lvl),
    .t1_cap_a(rt_t1a),
    .t1_cap_b(rt_t1b),
    .t2_cap_a(rt_t2a),
    .t2_cap_b(rt_t2b)
  );

  assign addr_take = hsel && htrans[1] && hready;
  assign gp_out = {out_up_r, out_lo_r};
  assign gp_oe = {drv_up_r, drv_lo_r};

  // Address phase and data phase tracking
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      idx_r <= 16'h0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      case (state_r)
        ST_READ: begin
          // Wait state over, read data now stands
          hreadyout <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          if (addr_take) begin
            idx_r <= haddr[17:2];
            if (hwrite) begin
              state_r <= ST_WRITE;
            end else begin
              // One wait state lets a write just before be seen
              state_r <= ST_READ;
              hreadyout <= 1'b0;
            end
          end else begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= `GPR_CFG_RST;
      out_up_r <= `GPR_OUT_UP_RST;
      out_lo_r <= `GPR_OUT_LO_RST;
      drv_up_r <= `GPR_DRV_UP_RST;
      drv_lo_r <= `GPR_DRV_LO_RST;
    end else if (state_r == ST_WRITE) begin
      if (idx_r == `GPR_IDX_CFG) begin
        cfg_r <= hwdata[`GPR_CFG_W-1:0];
      end else if (idx_r == `GPR_IDX_OUT_UP) begin
        out_up_r <= hwdata[0];
      end else if (idx_r == `GPR_IDX_OUT_LO) begin
        out_lo_r <= hwdata[15:0];
      end else if (idx_r == `GPR_IDX_SET_UP) begin
        if (hwdata[0]) begin
          out_up_r <= 1'b1;
        end
      end else if (idx_r == `GPR_IDX_DRV_UP) begin
        drv_up_r <= hwdata[0];
      end else if (idx_r == `GPR_IDX_DRV_LO) begin
        drv_lo_r <= hwdata[15:0];
      end
    end
  end

  // Read multiplexer; unmapped and write-only words read zero
  always @* begin
    rd_nxt = 32'h00000000;
    if (idx_r == `GPR_IDX_IN_UP) begin
      rd_nxt[0] = lvl[16];
    end else if (idx_r == `GPR_IDX_IN_LO) begin
      rd_nxt[15:0] = lvl[15:0];
    end else if (idx_r == `GPR_IDX_OUT_UP) begin
      rd_nxt[0] = out_up_r;
    end else if (idx_r == `GPR_IDX_OUT_LO) begin
      rd_nxt[15:0] = out_lo_r;
    end else if (idx_r == `GPR_IDX_SET_UP) begin
      rd_nxt = 32'h00000000;
    end else if (idx_r == `GPR_IDX_CFG) begin
      rd_nxt[`GPR_CFG_W-1:0] = cfg_r;
    end else if (idx_r == `GPR_IDX_DRV_UP) begin
      rd_nxt[0] = drv_up_r;
    end else if (idx_r == `GPR_IDX_DRV_LO) begin
      rd_nxt[15:0] = drv_lo_r;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (state_r == ST_READ) begin
      hrdata <= rd_nxt;
    end
  end

  // Pin drive: alternate functions override the stored output and enable
  always @* begin
    pin_out_nxt = gp_out;
    pin_oe_nxt = gp_oe;
    if (cfg_r[`GPR_CFG_PTI]) begin
      pin_out_nxt[`GPR_PIN_TRACE_EN] = trace_frame_enable;
      pin_oe_nxt[`GPR_PIN_TRACE_EN] = 1'b1;
      pin_out_nxt[`GPR_PIN_TRACE_DATA] = trace_serial_out;
      pin_oe_nxt[`GPR_PIN_TRACE_DATA] = 1'b1;
    end
    if (cfg_r[`GPR_CFG_T2OA]) begin
      pin_out_nxt[`GPR_PIN_T2OA] = timer_two_output_a;
      pin_oe_nxt[`GPR_PIN_T2OA] = 1'b1;
    end
    if (cfg_r[`GPR_CFG_T2OB]) begin
      pin_out_nxt[`GPR_PIN_T2OB] = timer_two_output_b;
      pin_oe_nxt[`GPR_PIN_T2OB] = 1'b1;
    end
    if (cfg_r[`GPR_CFG_T1OA]) begin
      pin_out_nxt[`GPR_PIN_T1OA] = timer_one_output_a;
      pin_oe_nxt[`GPR_PIN_T1OA] = 1'b1;
    end
    if (cfg_r[`GPR_CFG_T1OB]) begin
      pin_out_nxt[`GPR_PIN_T1OB] = timer_one_output_b;
      pin_oe_nxt[`GPR_PIN_T1OB] = 1'b1;
    end
  end

  // Every output leaves through a flop, costing one cycle of latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= {NPINS{1'b0}};
      pin_oe <= {NPINS{1'b0}};
      timer_one_capture_a <= 1'b0;
      timer_one_capture_b <= 1'b0;
      timer_two_capture_a <= 1'b0;
      timer_two_capture_b <= 1'b0;
      timer_one_ext_clock <= 1'b0;
      timer_two_ext_clock <= 1'b0;
      timer_one_enable_mask <= 1'b0;
      timer_two_enable_mask <= 1'b0;
      ext_interrupt_a <= 1'b0;
      ext_interrupt_b <= 1'b0;
      ext_interrupt_c <= 1'b0;
      ext_interrupt_d <= 1'b0;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe <= pin_oe_nxt;
      timer_one_capture_a <= rt_t1a;
      timer_one_capture_b <= rt_t1b;
      timer_two_capture_a <= rt_t2a;
      timer_two_capture_b <= rt_t2b;
      timer_two_ext_clock <= lvl[`GPR_PIN_T2CLK];
      timer_one_enable_mask <= lvl[`GPR_PIN_T2CLK];
      timer_one_ext_clock <= lvl[`GPR_PIN_T1CLK];
      timer_two_enable_mask <= lvl[`GPR_PIN_T1CLK];
      ext_interrupt_a <= lvl[8];
      ext_interrupt_b <= lvl[14];
      ext_interrupt_c <= lvl[15];
      ext_interrupt_d <= lvl[16];
    end
  end
endmodule // gpr_top
`default_nettype wire

/* pkg/gpr_defines.vh */
// Register indices, field positions and reset values of the pin routing port
`ifndef GPR_DEFINES_VH
`define GPR_DEFINES_VH

// Register indices; byte address is four times the index
`define GPR_IDX_IN_UP 16'h4700
`define GPR_IDX_IN_LO 16'h4702
`define GPR_IDX_OUT_UP 16'h4704
`define GPR_IDX_OUT_LO 16'h4706
`define GPR_IDX_SET_UP 16'h4708
`define GPR_IDX_CFG 16'h4712
`define GPR_IDX_DRV_UP 16'h4730
`define GPR_IDX_DRV_LO 16'h4732

// Configuration register
`define GPR_CFG_RST 15'h2000
`define GPR_CFG_W 15
`define GPR_CFG_T2OA 0
`define GPR_CFG_T2OB 1
`define GPR_CFG_T1OA 2
`define GPR_CFG_T1OB 3
`define GPR_CFG_CODE_LSB 4
`define GPR_CFG_CODE_MSB 7
`define GPR_CFG_PTI 13

// Output register reset values
`define GPR_OUT_UP_RST 1'h0
`define GPR_OUT_LO_RST 16'h0000
`define GPR_DRV_UP_RST 1'h0
`define GPR_DRV_LO_RST 16'h0000

// Timer one capture routing alternatives
`define GPR_T1_FIRST 3'h0
`define GPR_T1_SECOND 3'h1
`define GPR_T1_SECOND_HALF 3'h2
`define GPR_T1_THIRD 3'h3
`define GPR_T1_THIRD_HALF 3'h4

// Timer two capture routing alternatives
`define GPR_T2_FIRST 2'h0
`define GPR_T2_SECOND 2'h1
`define GPR_T2_THIRD 2'h2

// Pin numbers of fixed functions
`define GPR_PIN_TRACE_EN 4
`define GPR_PIN_TRACE_DATA 5
`define GPR_PIN_T2CLK 6
`define GPR_PIN_T1CLK 8
`define GPR_PIN_T2OA 13
`define GPR_PIN_T2OB 14
`define GPR_PIN_T1OA 15
`define GPR_PIN_T1OB 16

`endif

/* logic/gpr_sync.v */
// Three-stage input synchroniser with agreement filter, one lane per pin
`default_nettype none
module gpr_sync #(
  parameter WIDTH = 17
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      // Only the second and third stages are compared; the first may be metastable
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= async_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level[i] = lvl_r;
    end
  endgenerate
endmodule // gpr_sync
`default_nettype wire

/* logic/gpr_route.v */
// Capture-input routing decoded from the joint serial and capture code
`include "gpr_defines.vh"
`default_nettype none
module gpr_route (
  input wire [3:0] code,
  input wire [16:0] lvl,
  output reg t1_cap_a,
  output reg t1_cap_b,
  output reg t2_cap_a,
  output reg t2_cap_b
);
  reg [2:0] t1_mode;
  reg [1:0] t2_mode;

  always @* begin
    case (code)
      4'h0: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_FIRST; end
      4'h1: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_FIRST; end
      4'h2: begin t1_mode = `GPR_T1_THIRD_HALF; t2_mode = `GPR_T2_THIRD; end
      4'h3: begin t1_mode = `GPR_T1_THIRD; t2_mode = `GPR_T2_THIRD; end
      4'h4: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_FIRST; end
      4'h5: begin t1_mode = `GPR_T1_THIRD_HALF; t2_mode = `GPR_T2_FIRST; end
      4'h6: begin t1_mode = `GPR_T1_THIRD; t2_mode = `GPR_T2_THIRD; end
      4'h7: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_SECOND; end
      4'h8: begin t1_mode = `GPR_T1_SECOND_HALF; t2_mode = `GPR_T2_FIRST; end
      4'h9: begin t1_mode = `GPR_T1_THIRD; t2_mode = `GPR_T2_FIRST; end
      4'hA: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_SECOND; end
      4'hB: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_THIRD; end
      4'hC: begin t1_mode = `GPR_T1_SECOND; t2_mode = `GPR_T2_FIRST; end
      4'hD: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_FIRST; end
      4'hE: begin t1_mode = `GPR_T1_FIRST; t2_mode = `GPR_T2_THIRD; end
      default: begin t1_mode = `GPR_T1_THIRD_HALF; t2_mode = `GPR_T2_THIRD; end
    endcase
  end

  // Half alternatives route only the A input; B then reads low
  always @* begin
    t1_cap_a = 1'b0;
    t1_cap_b = 1'b0;
    case (t1_mode)
      `GPR_T1_FIRST: begin
        t1_cap_a = lvl[0];
        t1_cap_b = lvl[3];
      end
      `GPR_T1_SECOND: begin
        t1_cap_a = lvl[9];
        t1_cap_b = lvl[10];
      end
      `GPR_T1_SECOND_HALF: begin
        t1_cap_a = lvl[9];
      end
      `GPR_T1_THIRD: begin
        t1_cap_a = lvl[13];
        t1_cap_b = lvl[14];
      end
      `GPR_T1_THIRD_HALF: begin
        t1_cap_a = lvl[13];
      end
      default: begin
        t1_cap_a = 1'b0;
      end
    endcase
  end

  always @* begin
    t2_cap_a = 1'b0;
    t2_cap_b = 1'b0;
    case (t2_mode)
      `GPR_T2_FIRST: begin
        t2_cap_a = lvl[11];
        t2_cap_b = lvl[12];
      end
      `GPR_T2_SECOND: begin
        t2_cap_a = lvl[1];
        t2_cap_b = lvl[2];
      end
      `GPR_T2_THIRD: begin
        t2_cap_a = lvl[15];
        t2_cap_b = lvl[16];
      end
      default: begin
        t2_cap_a = 1'b0;
      end
    endcase
  end
endmodule // gpr_route
`default_nettype wire

/* testbench/gpr_top_monitor.sv */
// Concurrent checks on the pin routing port, bound to its top module
`include "gpr_defines.vh"
`default_nettype none
module gpr_monitor #(
  parameter NPINS = 17
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic trace_frame_enable,
  input wire logic trace_serial_out,
  input wire logic timer_one_ext_clock,
  input wire logic timer_two_ext_clock,
  input wire logic timer_one_enable_mask,
  input wire logic ext_interrupt_a,
  input wire logic ext_interrupt_d
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic cfg_w_r;
  assign take = hsel && htrans[1] && hready;
  // Trace default only holds until software first writes the configuration
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_w_r <= 1'b0;
    end else if (take && hwrite && haddr[17:2] == `GPR_IDX_CFG) begin
      cfg_w_r <= 1'b1;
    end
  end
  sequence s_rd_take; take && !hwrite; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_steady(logic s); $stable(s) [*8]; endsequence
  property p_rd_wait; s_rd_take |=> s_one_wait; endproperty
  property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_irq_a; s_steady(pin_in[8]) |-> ext_interrupt_a == pin_in[8]; endproperty
  property p_irq_d; s_steady(pin_in[16]) |-> ext_interrupt_d == pin_in[16]; endproperty
  property p_clk_one; s_steady(pin_in[8]) |-> timer_one_ext_clock == pin_in[8]; endproperty
  property p_clk_two;
    s_steady(pin_in[6]) |-> timer_two_ext_clock == pin_in[6] && timer_one_enable_mask == pin_in[6];
  endproperty
  property p_trace;
    $past(hresetn) && !cfg_w_r |-> pin_oe[5:4] == 2'b11 && pin_out[4] == $past(trace_frame_enable)
      && pin_out[5] == $past(trace_serial_out);
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state not one cycle");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write was stalled");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_irq_a: assert property (p_irq_a) else $error("interrupt a off pin 8");
  a_irq_d: assert property (p_irq_d) else $error("interrupt d off pin 16");
  a_clk_one: assert property (p_clk_one) else $error("timer one clock off pin 8");
  a_clk_two: assert property (p_clk_two) else $error("pin 6 functions wrong");
  a_trace: assert property (p_trace) else $error("trace pins not routed");
endmodule // gpr_monitor
bind gpr_top gpr_monitor #(.NPINS(NPINS)) u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .trace_frame_enable(trace_frame_enable), .trace_serial_out(trace_serial_out),
  .timer_one_ext_clock(timer_one_ext_clock),
  .timer_two_ext_clock(timer_two_ext_clock), .timer_one_enable_mask(timer_one_enable_mask),
  .ext_interrupt_a(ext_interrupt_a), .ext_interrupt_d(ext_interrupt_d));
`default_nettype wire

/* testbench/gpr_pin_model.sv */
// External pads: a driven pin reads back the port, a released pin the outside level
`default_nettype none
module gpr_pin_model (
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe,
  input wire logic [16:0] ext_lvl,
  output logic [16:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpr_pin_model
`default_nettype wire

/* testbench/tb_gpio_port_pin_routing.sv */
// Self-checking bench for the pin routing port
`include "gpr_defines.vh"
`default_nettype none
module tb_gpio_port_pin_routing;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] t1_tab = 64'h4001_0032_0340_3400;
  localparam logic [63:0] t2_tab = 64'h2200_2100_1200_2200;
  logic hclk, hresetn, hsel, hwrite, rd_ph;
  logic [31:0] haddr, hwdata, v;
  logic [1:0] htrans, trc;
  logic [16:0] ext_lvl;
  logic [3:0] tmr_o;
  wire logic hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [16:0] pin_in, pin_out, pin_oe;
  wire logic [3:0] cap, aux, irq;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] exp_q[$];
  string nm_q[$];
  gpr_top #(.NPINS(17)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .timer_one_output_a(tmr_o[0]),
    .timer_one_output_b(tmr_o[1]), .timer_two_output_a(tmr_o[2]),
    .timer_two_output_b(tmr_o[3]), .trace_frame_enable(trc[0]), .trace_serial_out(trc[1]),
    .timer_one_capture_a(cap[0]), .timer_one_capture_b(cap[1]), .timer_two_capture_a(cap[2]),
    .timer_two_capture_b(cap[3]), .timer_one_ext_clock(aux[0]), .timer_two_ext_clock(aux[1]),
    .timer_one_enable_mask(aux[2]), .timer_two_enable_mask(aux[3]), .ext_interrupt_a(irq[0]),
    .ext_interrupt_b(irq[1]), .ext_interrupt_c(irq[2]), .ext_interrupt_d(irq[3]));
  gpr_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Reads leave their expectation in the queue; the watcher below compares
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d, input string n);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'b00};
    if (!w) begin
      exp_q.push_back(d);
      nm_q.push_back(n);
    end
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge hclk);
  endtask
  function automatic logic [3:0] cap_exp(input logic [3:0] c, input logic [16:0] p);
    logic [3:0] m1;
    logic [3:0] m2;
    m1 = t1_tab[4*c +: 4];
    m2 = t2_tab[4*c +: 4];
    cap_exp[0] = m1 == 0 ? p[0] : m1 < 3 ? p[9] : p[13];
    cap_exp[1] = m1 == 0 ? p[3] : m1 == 1 ? p[10] : m1 == 3 ? p[14] : 1'b0;
    cap_exp[2] = m2 == 0 ? p[11] : m2 == 1 ? p[1] : p[15];
    cap_exp[3] = m2 == 0 ? p[12] : m2 == 1 ? p[2] : p[16];
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      chk(nm_q.pop_front(), exp_q.pop_front(), hrdata);
    end
    if (hreadyout) begin
      rd_ph <= hsel && htrans[1] && !hwrite;
    end
  end
  // Trace inputs wander every cycle so the default routing is really exercised
  always @(posedge hclk) begin
    trc <= 2'($urandom);
  end
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    ext_lvl = 17'h0;
    tmr_o = 4'h0;
    v = $urandom(6);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `GPR_IDX_CFG, 32'h0000_2000, "cfg");
    bus(0, `GPR_IDX_OUT_LO, 32'h0, "out_lo");
    bus(0, `GPR_IDX_OUT_UP, 32'h0, "out_up");
    bus(0, `GPR_IDX_SET_UP, 32'h0, "set_up");
    bus(0, 16'h4710, 32'h0, "unmapped");
    bus(1, `GPR_IDX_CFG, 32'hFFFF_FFFF, "");
    bus(0, `GPR_IDX_CFG, 32'h0000_7FFF, "cfg_all");
    $display("test reset and config done");
    bus(1, `GPR_IDX_CFG, 32'h0, "");
    v = $urandom;
    bus(1, `GPR_IDX_OUT_LO, v, "");
    ext_lvl <= {1'b0, ~v[15:0]};
    bus(0, `GPR_IDX_OUT_LO, {16'h0, v[15:0]}, "out_lo_rd");
    wt(8);
    chk("pin_out_lo", {16'h0, v[15:0]}, {16'h0, pin_out[15:0]});
    bus(0, `GPR_IDX_IN_LO, {16'h0, ~v[15:0]}, "in_lo_vs_out");
    bus(1, `GPR_IDX_OUT_UP, 32'hFFFF_FFFE, "");
    bus(0, `GPR_IDX_OUT_UP, 32'h0, "out_up_rd");
    bus(1, `GPR_IDX_SET_UP, 32'h1, "");
    bus(0, `GPR_IDX_OUT_UP, 32'h1, "set_one");
    bus(1, `GPR_IDX_SET_UP, 32'hFFFF_FFFE, "");
    bus(0, `GPR_IDX_OUT_UP, 32'h1, "set_zero");
    bus(0, `GPR_IDX_SET_UP, 32'h0, "set_rd");
    wt(2);
    chk("pin_out_16", 32'h1, {31'h0, pin_out[16]});
    $display("test outputs done");
    repeat (3) begin
      @(posedge hclk);
      v = $urandom;
      ext_lvl <= v[16:0];
      wt(8);
      bus(0, `GPR_IDX_IN_LO, {16'h0, v[15:0]}, "in_lo");
      bus(0, `GPR_IDX_IN_UP, {31'h0, v[16]}, "in_up");
      bus(1, `GPR_IDX_IN_LO, ~v, "");
      bus(0, `GPR_IDX_IN_LO, {16'h0, v[15:0]}, "in_lo_ro");
    end
    $display("test inputs done");
    for (int c = 0; c < 16; c++) begin
      bus(1, `GPR_IDX_CFG, c << 4, "");
      v = $urandom;
      ext_lvl <= v[16:0];
      wt(8);
      chk("captures", cap_exp(c[3:0], v[16:0]), cap);
      chk("pin6_pin8", {v[8], v[6], v[6], v[8]}, aux);
      chk("interrupts", {v[16], v[15], v[14], v[8]}, irq);
    end
    $display("test routing done");
    bus(1, `GPR_IDX_CFG, 32'h0000_000F, "");
    v = $urandom;
    tmr_o <= v[3:0];
    wt(3);
    chk("timer_pins", {v[1], v[0], v[3], v[2]}, pin_out[16:13]);
    chk("timer_oe", 32'hF, {28'h0, pin_oe[16:13]});
    bus(1, `GPR_IDX_CFG, 32'h0, "");
    v = $urandom;
    bus(1, `GPR_IDX_DRV_LO, v, "");
    bus(1, `GPR_IDX_DRV_UP, 32'h1, "");
    bus(0, `GPR_IDX_DRV_LO, {16'h0, v[15:0]}, "drv_lo_rd");
    bus(0, `GPR_IDX_DRV_UP, 32'h1, "drv_up_rd");
    wt(2);
    chk("pin_oe", {15'h0, 1'b1, v[15:0]}, {15'h0, pin_oe});
    $display("test timer outputs done");
    report_and_stop();
  end
endmodule // tb_gpio_port_pin_routing
`default_nettype wire
